//--- hdl/dcil_ctrl.sv
`timescale 1ns/1ps
`include "dcil_defines.svh"
module dcil_ctrl (
    input wire logic clk_sys,
    input wire logic resetn,
    dcil_if.ctl link,
    input wire logic [3:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [3:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [6:0] ctrl;
        logic [4:0] cmd;
        logic [21:0] adr;
        logic issue;
        logic awH;
        logic [3:0] awA;
        logic wH;
        logic [31:0] wD;
        logic [3:0] wS;
        logic bV;
        logic [1:0] bR;
        logic rV;
        logic [31:0] rD;
        logic [1:0] rR;
    } dcil_ctl_t;
    dcil_ctl_t st_r;
    dcil_ctl_t st_nxt;
    logic parBit;
    // Even parity over all covered pins; CS_n, CKE and ODT left out
    // Unused address bits are masked so both ends agree on the sum
    assign parBit = ^{st_r.adr[17:0] & `DCIL_ADDR_USED_MASK, st_r.adr[21:18], st_r.cmd[3:0]}
        ^ st_r.ctrl[`DCIL_CTRL_BADPAR];
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.issue = 1'b0;
        if (awvalid && !st_r.awH && !st_r.bV)
        begin
            st_nxt.awH = 1'b1;
            st_nxt.awA = awaddr;
        end
        if (wvalid && !st_r.wH && !st_r.bV)
        begin
            st_nxt.wH = 1'b1;
            st_nxt.wD = wdata;
            st_nxt.wS = wstrb;
        end
        if (st_r.awH && st_r.wH)
        begin
            st_nxt.awH = 1'b0;
            st_nxt.wH = 1'b0;
            st_nxt.bV = 1'b1;
            st_nxt.bR = 2'h0;
            case (st_r.awA)
                `DCIL_REG_CTRL: if (st_r.wS[0]) st_nxt.ctrl = st_r.wD[6:0];
                `DCIL_REG_CMD:
                begin
                    st_nxt.cmd = st_r.wD[4:0];
                    st_nxt.issue = 1'b1;
                end
                `DCIL_REG_ADDR: st_nxt.adr = st_r.wD[21:0];
                default: st_nxt.bR = 2'h2;
            endcase
        end
        if (st_r.bV && bready)
            st_nxt.bV = 1'b0;
        if (arvalid && !st_r.rV)
        begin
            st_nxt.rV = 1'b1;
            st_nxt.rR = 2'h0;
            case (araddr)
                `DCIL_REG_CTRL: st_nxt.rD = {25'h0, st_r.ctrl};
                `DCIL_REG_CMD: st_nxt.rD = {27'h0, st_r.cmd};
                `DCIL_REG_ADDR: st_nxt.rD = {10'h0, st_r.adr};
                `DCIL_REG_STAT: st_nxt.rD = {31'h0, st_r.issue};
                default:
                begin
                    st_nxt.rD = 32'h0;
                    st_nxt.rR = 2'h2;
                end
            endcase
        end
        else if (st_r.rV && rready)
            st_nxt.rV = 1'b0;
    end
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            st_r <= '0;
            st_r.ctrl <= 7'h10;
            st_r.cmd <= 5'h1f;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
    // ----------------------------------------
    // Pins; all change on the rising clock
    // ----------------------------------------
    // Software must keep CKE high over accesses; no enforcement here
    assign link.cke = st_r.ctrl[1:0];
    assign link.odt = st_r.ctrl[3:2];
    assign link.resetN = st_r.ctrl[`DCIL_CTRL_RST];
    assign link.ten = st_r.ctrl[`DCIL_CTRL_TEN];
    // Command pins only meaningful for one cycle after a write to CMD
    assign link.csN = st_r.issue ? {st_r.cmd[4], st_r.cmd[4]} : 2'h3;
    assign link.actN = st_r.cmd[3];
    assign link.rasN = st_r.cmd[2];
    assign link.casN = st_r.cmd[1];
    assign link.weN = st_r.cmd[0];
    assign link.addr = st_r.adr[17:0];
    assign link.ba = st_r.adr[19:18];
    assign link.bg = st_r.adr[21:20];
    assign link.par = parBit;
    assign link.dmN = 1'b1;
    assign link.dqsRise = 1'b0;
    assign link.wrBeat = 1'b0;
    assign link.dqIn = 8'h00;
    assign awready = !st_r.awH && !st_r.bV;
    assign wready = !st_r.wH && !st_r.bV;
    assign bvalid = st_r.bV;
    assign bresp = st_r.bR;
    assign arready = !st_r.rV;
    assign rvalid = st_r.rV;
    assign rdata = st_r.rD;
    assign rresp = st_r.rR;
endmodule // dcil_ctrl

//--- hdl/dcil_defines.svh
`ifndef DCIL_DEFINES_SVH
`define DCIL_DEFINES_SVH
// ----------------------------------------
// Widths and field positions
// ----------------------------------------
`define DCIL_ADDR_W 18
`define DCIL_DQ_W 8
`define DCIL_RANKS 2
`define DCIL_MR_W 8
// Mode control bits inside modeCfg
`define DCIL_MR_DM_EN 0
`define DCIL_MR_ODT_EN 1
`define DCIL_MR_TDQS_EN 2
`define DCIL_MR_PAR_EN 3
`define DCIL_MR_X8 4
// Address bits in use for this density; the rest count as zero in parity
`define DCIL_ADDR_USED_MASK 18'h1ffff
`define DCIL_MR_RESET 8'h00
// ----------------------------------------
// Controller register map (AXI4-Lite byte addresses)
// ----------------------------------------
`define DCIL_REG_CTRL 4'h0
`define DCIL_REG_CMD 4'h4
`define DCIL_REG_ADDR 4'h8
`define DCIL_REG_STAT 4'hc
// CTRL bits
`define DCIL_CTRL_CKE0 0
`define DCIL_CTRL_CKE1 1
`define DCIL_CTRL_ODT0 2
`define DCIL_CTRL_ODT1 3
`define DCIL_CTRL_RST 4
`define DCIL_CTRL_TEN 5
`define DCIL_CTRL_BADPAR 6
`endif

//--- hdl/dcil_device.sv
`timescale 1ns/1ps
`include "dcil_defines.svh"
module dcil_device (
    input wire logic clk_sys,
    dcil_if.dev link,
    input wire logic [7:0] modeCfg,
    input wire logic [1:0] selfRefReq,
    input wire logic [1:0] rowOpen,
    output logic [1:0] clkRun,
    output logic [1:0] inBufOn,
    output logic [1:0] ctlBufOn,
    output logic [1:0] termOn,
    output logic [1:0] tdqsTermOn,
    output logic [3:0] pwrState0,
    output logic [3:0] pwrState1,
    output logic [1:0] cmdValid,
    output logic [4:0] cmdCode,
    output logic actValid,
    output logic [2:0] actRowHi,
    output logic parErr,
    output logic wrValid,
    output logic [7:0] wrData,
    output logic testMode
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        dcil_pkg::dcil_pwr_t [1:0] pwr;
        logic [1:0] term;
        logic [1:0] cmdV;
        logic [4:0] cmd;
        logic actV;
        logic [2:0] rowHi;
        logic parE;
        logic wrV;
        logic [7:0] wrD;
    } dcil_dev_t;
    dcil_dev_t st_r;
    dcil_dev_t st_nxt;
    logic [1:0] sref;
    logic [17:0] parAddr;
    logic parCalc;
    logic anySel;
    // Self-refresh exit is asynchronous on CKE, so it gates buffers combinationally
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : gRank
            assign sref[g] = (st_r.pwr[g] == dcil_pkg::DCIL_SREF) && !link.cke[g];
            assign clkRun[g] = link.cke[g] && link.resetN;
            assign inBufOn[g] = link.cke[g] && link.resetN;
            assign ctlBufOn[g] = !sref[g] && link.resetN;
        end
    endgenerate
    assign parAddr = link.addr & `DCIL_ADDR_USED_MASK;
    // CS_n, CKE and ODT stay out of the sum
    assign parCalc = ^{parAddr, link.ba, link.bg, link.actN, link.rasN, link.casN, link.weN,
        link.par};
    assign anySel = !(&link.csN);
    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.cmdV = 2'h0;
        st_nxt.actV = 1'b0;
        st_nxt.parE = 1'b0;
        st_nxt.wrV = 1'b0;
        for (int i = 0; i < 2; i++)
        begin
            case (st_r.pwr[i])
                dcil_pkg::DCIL_IDLE:
                begin
                    if (!link.cke[i])
                    begin
                        if (rowOpen[i])
                            st_nxt.pwr[i] = dcil_pkg::DCIL_ACTPD;
                        else if (selfRefReq[i])
                            st_nxt.pwr[i] = dcil_pkg::DCIL_SREF;
                        else
                            st_nxt.pwr[i] = dcil_pkg::DCIL_PREPD;
                    end
                end
                dcil_pkg::DCIL_ACTPD, dcil_pkg::DCIL_PREPD, dcil_pkg::DCIL_SREF:
                begin
                    if (link.cke[i])
                        st_nxt.pwr[i] = dcil_pkg::DCIL_IDLE;
                end
                default: st_nxt.pwr[i] = dcil_pkg::DCIL_IDLE;
            endcase
            // Termination only when enabled and the rank's ODT buffer is alive
            st_nxt.term[i] = link.odt[i] && modeCfg[`DCIL_MR_ODT_EN]
                && st_r.pwr[i] != dcil_pkg::DCIL_SREF;
            if (link.cke[i] && st_r.pwr[i] == dcil_pkg::DCIL_IDLE && !link.csN[i])
                st_nxt.cmdV[i] = 1'b1;
        end
        if (anySel && !link.ten)
        begin
            st_nxt.cmd = {link.csN[0] & link.csN[1], link.actN, link.rasN, link.casN,
                link.weN};
            st_nxt.actV = !link.actN;
            st_nxt.rowHi = {link.rasN, link.casN, link.weN};
            st_nxt.parE = modeCfg[`DCIL_MR_PAR_EN] && parCalc;
        end
        // Mask only in x8 with mask enabled; one mask per strobe edge
        if (link.wrBeat)
        begin
            st_nxt.wrV = !(modeCfg[`DCIL_MR_X8] && modeCfg[`DCIL_MR_DM_EN]
                && !link.dmN);
            st_nxt.wrD = link.dqIn;
        end
    end
    // ----------------------------------------
    // Registers, sampled on the rising clock
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge link.resetN)
    begin
        if (!link.resetN)
        begin
            st_r <= '0;
            st_r.pwr <= {dcil_pkg::DCIL_IDLE, dcil_pkg::DCIL_IDLE};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
    assign termOn = st_r.term;
    assign tdqsTermOn = st_r.term
        & {2{modeCfg[`DCIL_MR_TDQS_EN] && modeCfg[`DCIL_MR_X8]}};
    assign pwrState0 = st_r.pwr[0];
    assign pwrState1 = st_r.pwr[1];
    assign cmdValid = st_r.cmdV;
    assign cmdCode = st_r.cmd;
    assign actValid = st_r.actV;
    assign actRowHi = st_r.rowHi;
    assign parErr = st_r.parE;
    assign wrValid = st_r.wrV;
    assign wrData = st_r.wrD;
    assign testMode = link.ten;
endmodule // dcil_device

//--- hdl/dcil_if.sv
`timescale 1ns/1ps
`include "dcil_defines.svh"
interface dcil_if;
    logic [1:0] cke;
    logic [1:0] csN;
    logic [1:0] odt;
    logic actN;
    logic rasN;
    logic casN;
    logic weN;
    logic [17:0] addr;
    logic [1:0] ba;
    logic [1:0] bg;
    logic par;
    logic resetN;
    logic ten;
    logic dmN;
    logic dqsRise;
    logic wrBeat;
    logic [7:0] dqIn;
    modport ctl (output cke, csN, odt, actN, rasN, casN, weN, addr, ba, bg, par,
        resetN, ten, dmN, dqsRise, wrBeat, dqIn);
    modport dev (input cke, csN, odt, actN, rasN, casN, weN, addr, ba, bg, par,
        resetN, ten, dmN, dqsRise, wrBeat, dqIn);
endinterface

//--- hdl/dcil_pkg.sv
package dcil_pkg;
    // Rank power state, one-hot
    typedef enum logic [3:0] {
        DCIL_IDLE = 4'h1,
        DCIL_ACTPD = 4'h2,
        DCIL_PREPD = 4'h4,
        DCIL_SREF = 4'h8
    } dcil_pwr_t;
    // Command written to the controller's command register: {cs_n,act_n,ras,cas,we}
    typedef logic [4:0] dcil_cmd_t;
endpackage

//--- verif/dcil_properties.sv
`timescale 1ns/1ps
`include "dcil_defines.svh"
module dcil_checker (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [1:0] cke,
    input wire logic [1:0] csN,
    input wire logic actN,
    input wire logic rasN,
    input wire logic casN,
    input wire logic weN,
    input wire logic [17:0] addr,
    input wire logic [1:0] ba,
    input wire logic [1:0] bg,
    input wire logic par,
    input wire logic resetN,
    input wire logic [7:0] modeCfg,
    input wire logic [1:0] rowOpen,
    input wire logic [1:0] clkRun,
    input wire logic [1:0] inBufOn,
    input wire logic [1:0] ctlBufOn,
    input wire logic [1:0] termOn,
    input wire logic [3:0] pwrState0,
    input wire logic [1:0] cmdValid,
    input wire logic [4:0] cmdCode,
    input wire logic parErr
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    logic parOdd;
    // A17 is unused at this density, so its level must not count
    assign parOdd = ^{par, addr & `DCIL_ADDR_USED_MASK, ba, bg, actN, rasN, casN, weN};
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    sequence s_cmd0;
        !csN[0] && cke[0] && resetN && pwrState0 == 4'h1;
    endsequence
    sequence s_pd0;
        (pwrState0 == 4'h2 || pwrState0 == 4'h4) && !cke[0];
    endsequence
    a_cs_mask: assert property (csN == 2'b11 |=> cmdValid == 2'b00)
        else $error("command taken with no rank selected");
    a_cmd_code: assert property (
        s_cmd0 |=> cmdValid[0] && cmdCode == {1'b0, $past(actN), $past(rasN), $past(casN),
        $past(weN)}) else $error("command code wrong");
    a_clk_cke: assert property (resetN |-> clkRun == cke)
        else $error("clock run differs from clock enable");
    a_pd_bufs: assert property (s_pd0 |-> !inBufOn[0] && ctlBufOn[0])
        else $error("buffers wrong in power-down");
    a_sref_bufs: assert property (
        pwrState0 == 4'h8 && !cke[0] |-> !inBufOn[0] && !ctlBufOn[0])
        else $error("buffers wrong in self refresh");
    a_act_pd: assert property (
        $fell(cke[0]) && rowOpen[0] && resetN && pwrState0 == 4'h1 |-> ##[1:2] pwrState0 == 4'h2)
        else $error("active power-down not entered");
    a_term_off: assert property (!modeCfg[1] [*2] |-> termOn == 2'b00)
        else $error("termination on while disabled");
    a_par_err: assert property (s_cmd0 ##0 modeCfg[3] |=> parErr == $past(parOdd))
        else $error("parity flag wrong");
    a_rst_idle: assert property (!resetN |-> pwrState0 == 4'h1)
        else $error("device not reset");
endmodule // dcil_checker

//--- verif/test_ddr4_control_input_logic.sv
`timescale 1ns/1ps
`include "dcil_defines.svh"
module test_ddr4_control_input_logic;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, actValid, parErr, wrValid, testMode;
    logic [1:0] bresp, rresp, clkRun, inBufOn, ctlBufOn, termOn, tdqsTermOn, cmdValid;
    logic [7:0] modeCfg = 8'h1f, wrData;
    logic [1:0] selfRefReq = 2'h0, rowOpen = 2'h0;
    logic [3:0] pwrState0, pwrState1;
    logic [4:0] cmdCode, lastCode;
    logic [2:0] actRowHi;
    int fails = 0, n_compared = 0, nCmd = 0, nAct = 0, nPar = 0;
    dcil_if link();
    dcil_ctrl u_dcil_ctrl (.clk_sys(clk_sys), .resetn(resetn), .link(link.ctl),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));
    dcil_device u_dcil_device (.clk_sys(clk_sys), .link(link.dev), .modeCfg(modeCfg),
        .selfRefReq(selfRefReq), .rowOpen(rowOpen), .clkRun(clkRun), .inBufOn(inBufOn),
        .ctlBufOn(ctlBufOn), .termOn(termOn), .tdqsTermOn(tdqsTermOn), .pwrState0(pwrState0),
        .pwrState1(pwrState1), .cmdValid(cmdValid), .cmdCode(cmdCode), .actValid(actValid),
        .actRowHi(actRowHi), .parErr(parErr), .wrValid(wrValid), .wrData(wrData),
        .testMode(testMode));
    dcil_checker u_dcil_checker (.clk_sys(clk_sys), .resetn(resetn), .cke(link.cke),
        .csN(link.csN), .actN(link.actN), .rasN(link.rasN), .casN(link.casN), .weN(link.weN),
        .addr(link.addr), .ba(link.ba), .bg(link.bg), .par(link.par), .resetN(link.resetN),
        .modeCfg(modeCfg), .rowOpen(rowOpen), .clkRun(clkRun), .inBufOn(inBufOn),
        .ctlBufOn(ctlBufOn), .termOn(termOn), .pwrState0(pwrState0), .cmdValid(cmdValid),
        .cmdCode(cmdCode), .parErr(parErr));
    always #12.5 clk_sys = ~clk_sys;
    // ----------------------------------------
    // Pulse monitor and bus tasks
    // ----------------------------------------
    always @(posedge clk_sys)
    begin
        if (cmdValid[0] === 1'b1) nCmd++;
        if (cmdValid[0] === 1'b1) lastCode = cmdCode;
        if (actValid === 1'b1) nAct++;
        if (parErr === 1'b1) nPar++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Ready is looked at mid-cycle so the release never races the edge
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic ta, tw, tb, pa, pw, pb;
        pa = 1'b1;
        pw = 1'b1;
        pb = 1'b1;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (pa || pw || pb)
        begin
            @(negedge clk_sys);
            ta = pa && awready;
            tw = pw && wready;
            tb = pb && bvalid;
            @(posedge clk_sys);
            if (ta) awvalid <= 1'b0;
            if (ta) pa = 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tw) pw = 1'b0;
            if (tb) bready <= 1'b0;
            if (tb) pb = 1'b0;
        end
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr, tk;
        ta = 1'b1;
        tr = 1'b0;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!tr)
        begin
            @(negedge clk_sys);
            tk = ta && arready;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk_sys);
            if (tk) arvalid <= 1'b0;
            if (tk) ta = 1'b0;
            if (tr) rready <= 1'b0;
        end
    endtask
    task automatic settle;
        repeat (4) @(posedge clk_sys);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        logic [31:0] d;
        logic [1:0] r;
        rd(`DCIL_REG_CTRL, d, r);
        chk(d, 32'h10);
        rd(`DCIL_REG_CMD, d, r);
        chk(d, 32'h1f);
        rd(4'h2, d, r);
        chk({30'h0, r}, 32'h2);
        chk({30'h0, clkRun}, 32'h0);
        $display("t_reset done");
    endtask
    task automatic t_cmd;
        wr(`DCIL_REG_CTRL, 32'h13);
        chk({30'h0, clkRun}, 32'h3);
        wr(`DCIL_REG_ADDR, 32'h1234);
        wr(`DCIL_REG_CMD, 32'h0b);
        settle();
        chk({27'h0, lastCode}, 32'h0b);
        wr(`DCIL_REG_CMD, 32'h1b);
        settle();
        chk(nCmd, 32'h1);
        wr(`DCIL_REG_CMD, 32'h02);
        settle();
        chk(nAct, 32'h1);
        chk({29'h0, actRowHi}, 32'h2);
        chk({31'h0, wrValid}, 32'h0);
        $display("t_cmd done");
    endtask
    task automatic t_parity;
        wr(`DCIL_REG_ADDR, 32'h20000);
        wr(`DCIL_REG_CMD, 32'h0b);
        settle();
        chk(nPar, 32'h0);
        wr(`DCIL_REG_CTRL, 32'h53);
        wr(`DCIL_REG_CMD, 32'h0b);
        settle();
        chk(nPar, 32'h1);
        wr(`DCIL_REG_CTRL, 32'h13);
        $display("t_parity done");
    endtask
    task automatic t_power;
        logic [3:0] want [3] = '{4'h2, 4'h4, 4'h8};
        for (int i = 0; i < 3; i++)
        begin
            rowOpen <= {1'b0, i == 0};
            selfRefReq <= {1'b0, i == 2};
            wr(`DCIL_REG_CTRL, 32'h12);
            settle();
            chk({28'h0, pwrState0}, {28'h0, want[i]});
            chk({30'h0, inBufOn}, 32'h2);
            chk({28'h0, pwrState1}, 32'h1);
            wr(`DCIL_REG_CTRL, 32'h13);
            chk({30'h0, clkRun}, 32'h3);
        end
        rowOpen <= 2'h0;
        selfRefReq <= 2'h0;
        $display("t_power done");
    endtask
    task automatic t_odt;
        wr(`DCIL_REG_CTRL, 32'h17);
        settle();
        chk({30'h0, termOn}, 32'h1);
        chk({30'h0, tdqsTermOn}, 32'h1);
        modeCfg <= 8'h1d;
        settle();
        chk({30'h0, termOn}, 32'h0);
        modeCfg <= 8'h1f;
        $display("t_odt done");
    endtask
    task automatic t_ten;
        wr(`DCIL_REG_CTRL, 32'h33);
        chk({31'h0, testMode}, 32'h1);
        wr(`DCIL_REG_CTRL, 32'h03);
        settle();
        chk({28'h0, pwrState0}, 32'h1);
        wr(`DCIL_REG_CTRL, 32'h13);
        $display("t_ten done");
    endtask
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        wrap_up();
    end
    initial
    begin
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        t_reset();
        t_cmd();
        t_parity();
        t_power();
        t_odt();
        t_ten();
        wrap_up();
    end
endmodule // test_ddr4_control_input_logic
